/* batmon_defs.vh */
// Constants for the battery monitor command port: offsets, codes, resets.
// Assumes inclusion by bare name from the design files.
`ifndef BATMON_DEFS_VH
`define BATMON_DEFS_VH

// ====================================================================
// Link addressing
`define DEV_ADDR        7'h08

// ====================================================================
// Register offsets
`define A_SAFETY_A      8'h03
`define A_SAFETY_B      8'h05
`define A_SAFETY_C      8'h07
`define A_PF_A          8'h0b
`define A_PF_B          8'h0d
`define A_PF_C          8'h0f
`define A_SUBCMD_LO     8'h3e
`define A_SUBCMD_HI     8'h3f
`define A_XFER_HI5      5'h08
`define A_CKSUM         8'h60
`define A_LEN           8'h61
`define A_ALARM_LO      8'h62
`define A_ALARM_HI      8'h63
`define A_TEMP1_LO      8'h70
`define A_TEMP1_HI      8'h71
`define A_TEMP2_LO      8'h72
`define A_TEMP2_HI      8'h73
`define A_TEMP3_LO      8'h74
`define A_TEMP3_HI      8'h75

// ====================================================================
// Subcommand codes and data memory window
`define SC_SHUTDOWN     16'h0010
`define SC_RESET        16'h0012
`define SC_PASSED_CHG   16'h0076
`define DM_BASE_HI12    12'h900
`define LEN_OVERHEAD    8'h04

// ====================================================================
// Data memory byte indices
`define DM_PROT_EN_A    4'h0
`define DM_FET_CTL_A    4'h3
`define DM_PF_EN_A      4'h6
`define DM_ALM_MASK_LO  4'h9
`define DM_ALM_MASK_HI  4'ha

// ====================================================================
// Reset values
`define RST_DM_SET      8'hff
`define RST_DM_SPARE    8'h00
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000

`endif

/* i2c_target_port.v */
// I2C target byte engine: address match, byte receive, byte transmit.
// Assumes scl_in and sda_in come from pins; SDA is open drain.
`timescale 1ns/1ps
`default_nettype none
`include "batmon_defs.vh"

module i2c_target_port (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst_b,
    // Bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    // Byte side
    output reg        wr_strb,
    output reg        wr_first,
    output reg  [7:0] wr_data,
    output reg        rd_take,
    input  wire [7:0] rd_byte
);

localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_ACKA = 3'h2;
localparam ST_WRX  = 3'h3;
localparam ST_ACKW = 3'h4;
localparam ST_TX   = 3'h5;
localparam ST_RACK = 3'h6;

reg [2:0] scl_s;
reg [2:0] sda_s;
reg       scl_f, scl_p, sda_f, sda_p;
reg [2:0] st_r, cnt_r;
reg       full_r, rw_r, first_r, nack_r;
reg [7:0] rx_sh, tx_sh;

wire scl_rise  = scl_f & ~scl_p;
wire scl_fall  = ~scl_f & scl_p;
wire start_det = sda_p & ~sda_f & scl_f & scl_p;
wire stop_det  = ~sda_p & sda_f & scl_f & scl_p;

// Only low is ever driven
assign sda_out = 1'b0;

// ====================================================================
// Pin synchronisers, accept a level once stages two and three agree
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        scl_s <= 3'h7;
        sda_s <= 3'h7;
        scl_f <= 1'b1;
        scl_p <= 1'b1;
        sda_f <= 1'b1;
        sda_p <= 1'b1;
    end else begin
        scl_s <= {scl_s[1:0], scl_in};
        sda_s <= {sda_s[1:0], sda_in};
        if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
        if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
        scl_p <= scl_f;
        sda_p <= sda_f;
    end
end

// ====================================================================
// Byte framing state machine
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        st_r     <= ST_IDLE;
        cnt_r    <= 3'h0;
        full_r   <= 1'b0;
        rw_r     <= 1'b0;
        first_r  <= 1'b0;
        nack_r   <= 1'b0;
        rx_sh    <= 8'h00;
        tx_sh    <= 8'h00;
        sda_oe   <= 1'b0;
        wr_strb  <= 1'b0;
        wr_first <= 1'b0;
        wr_data  <= 8'h00;
        rd_take  <= 1'b0;
    end else begin
        wr_strb <= 1'b0;
        rd_take <= 1'b0;
        if (start_det) begin
            st_r    <= ST_ADDR;
            cnt_r   <= 3'h0;
            full_r  <= 1'b0;
            first_r <= 1'b1;
            sda_oe  <= 1'b0;
        end else if (stop_det) begin
            st_r   <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            if (scl_rise) begin
                rx_sh  <= {rx_sh[6:0], sda_f};
                cnt_r  <= cnt_r + 3'h1;
                full_r <= (cnt_r == 3'h7);
                nack_r <= sda_f;
            end
            if (scl_fall) begin
                case (st_r)
                    ST_ADDR: begin
                        if (full_r) begin
                            if (rx_sh[7:1] == `DEV_ADDR) begin
                                sda_oe <= 1'b1;
                                rw_r   <= rx_sh[0];
                                st_r   <= ST_ACKA;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACKA, ST_RACK: begin
                        cnt_r  <= 3'h0;
                        full_r <= 1'b0;
                        if (st_r == ST_RACK && nack_r) begin
                            sda_oe <= 1'b0;
                            st_r   <= ST_IDLE;
                        end else if (rw_r) begin
                            tx_sh   <= rd_byte;
                            rd_take <= 1'b1;
                            sda_oe  <= ~rd_byte[7];
                            st_r    <= ST_TX;
                        end else begin
                            sda_oe <= 1'b0;
                            st_r   <= ST_WRX;
                        end
                    end
                    ST_WRX: begin
                        if (full_r) begin
                            sda_oe   <= 1'b1;
                            wr_strb  <= 1'b1;
                            wr_data  <= rx_sh;
                            wr_first <= first_r;
                            first_r  <= 1'b0;
                            st_r     <= ST_ACKW;
                        end
                    end
                    ST_ACKW: begin
                        sda_oe <= 1'b0;
                        cnt_r  <= 3'h0;
                        full_r <= 1'b0;
                        st_r   <= ST_WRX;
                    end
                    ST_TX: begin
                        if (full_r) begin
                            sda_oe <= 1'b0;
                            st_r   <= ST_RACK;
                        end else begin
                            tx_sh  <= {tx_sh[6:0], 1'b0};
                            sda_oe <= ~tx_sh[6];
                        end
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end
end

endmodule // i2c_target_port
`default_nettype wire

/* battery_monitor_cmd_port.v */
// Battery monitor command port: register map, subcommands and alarms.
// Assumes fault, alarm and measurement inputs come from core_clk logic.
// What this block does
// - Registers are reached bytewise at a host-supplied register address.
// - Direct commands read data from, or write data to, the address.
// - Data subcommand: code to 0x3E, then checksum to 0x60 and length to 0x61 validate.
// - Alarm status at 0x62 latches a bit on masked flag rising edge.
// - Writing one clears an alarm bit; zero bits stay unchanged.
// - Interrupt pin asserted while any latched alarm bit is set.
// - Safety flags read at 0x03/0x05/0x07; faults can raise interrupt.
// - Each protection enabled separately; separate choice of switch control.
// - Permanent-fail conditions configurably set permanent-fail flags.
// - Latest temperature of each of three thermistors, own command each.
// - Subcommand 0x0076 returns 64-bit passed charge and time.
// - Multi-byte values go least significant byte first.
// - Permanent-fail status read at 0x0B, 0x0D and 0x0F.
`timescale 1ns/1ps
`default_nettype none
`include "batmon_defs.vh"

module battery_monitor_cmd_port (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // Bus pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe,
    // Protection and fault sources
    input  wire [7:0]  fault_a,
    input  wire [7:0]  fault_b,
    input  wire [7:0]  fault_c,
    input  wire [7:0]  permanent_fail_a,
    input  wire [7:0]  permanent_fail_b,
    input  wire [7:0]  permanent_fail_c,
    input  wire [15:0] alarm_in,
    // Measurements
    input  wire [15:0] thermistor_input_1,
    input  wire [15:0] thermistor_input_2,
    input  wire [15:0] thermistor_input_3,
    input  wire [63:0] passed_charge_status,
    // Outputs to host and power stage
    output wire        alert_out,
    output reg         fet_off,
    output reg         shutdown_pulse,
    output reg         reset_pulse
);

wire       wr_strb, wr_first, rd_take;
wire [7:0] wr_data;
reg  [7:0] rd_byte;

reg  [7:0]  ptr_r, cksum_r, len_r;
reg  [15:0] subcmd_r;
reg  [7:0]  xfer_r [0:7];
reg  [7:0]  dm_r   [0:15];
reg  [7:0]  safety_a_r, safety_b_r, safety_c_r;
reg  [7:0]  pf_a_r, pf_b_r, pf_c_r;
reg  [15:0] alarm_r, alarm_prev_r;
integer     i;

wire        data_wr  = wr_strb & ~wr_first;
wire [15:0] sc_new   = {wr_data, subcmd_r[7:0]};
wire        sc_in_dm = (subcmd_r[15:4] == `DM_BASE_HI12);

// Checksum: inverted byte sum of code and data
function [7:0] cks;
    input [7:0] a, b, c, d;
    begin
        cks = ~(a + b + c + d);
    end
endfunction

// ====================================================================
// Bus byte engine
i2c_target_port u_link (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .wr_strb  (wr_strb),
    .wr_first (wr_first),
    .wr_data  (wr_data),
    .rd_take  (rd_take),
    .rd_byte  (rd_byte)
);

// ====================================================================
// Pointer, subcommand registers, transfer buffer and data memory
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        ptr_r          <= `RST_BYTE;
        cksum_r        <= `RST_BYTE;
        len_r          <= `RST_BYTE;
        subcmd_r       <= `RST_WORD;
        shutdown_pulse <= 1'b0;
        reset_pulse    <= 1'b0;
        for (i = 0; i < 8; i = i + 1)
            xfer_r[i] <= `RST_BYTE;
        for (i = 0; i < 16; i = i + 1)
            dm_r[i] <= (i < 11) ? `RST_DM_SET : `RST_DM_SPARE;
    end else begin
        shutdown_pulse <= 1'b0;
        reset_pulse    <= 1'b0;
        if (wr_strb && wr_first) begin
            ptr_r <= wr_data;
        end else if (data_wr || rd_take) begin
            ptr_r <= ptr_r + 8'h01;
        end
        if (data_wr) begin
            case (ptr_r)
                `A_SUBCMD_LO: subcmd_r[7:0] <= wr_data;
                `A_SUBCMD_HI: begin
                    subcmd_r[15:8] <= wr_data;
                    // Command-only codes act on completion
                    if (sc_new == `SC_SHUTDOWN) shutdown_pulse <= 1'b1;
                    if (sc_new == `SC_RESET) reset_pulse <= 1'b1;
                    // Read-kind subcommands fill the buffer
                    for (i = 0; i < 8; i = i + 1) begin
                        if (sc_new == `SC_PASSED_CHG)
                            xfer_r[i] <= passed_charge_status[8*i +: 8];
                        else if (sc_new[15:4] == `DM_BASE_HI12 &&
                                 sc_new[3:0] <= 4'hf - i[3:0])
                            xfer_r[i] <= dm_r[sc_new[3:0] + i[3:0]];
                        else
                            xfer_r[i] <= `RST_BYTE;
                    end
                end
                `A_CKSUM: cksum_r <= wr_data;
                `A_LEN: begin
                    len_r <= wr_data;
                    // Commit a write only when checksum and length hold
                    if (sc_in_dm && wr_data == `LEN_OVERHEAD + 8'h01 &&
                        cksum_r == cks(subcmd_r[7:0], subcmd_r[15:8],
                                       xfer_r[0], 8'h00)) begin
                        dm_r[subcmd_r[3:0]] <= xfer_r[0];
                    end else if (sc_in_dm && wr_data == `LEN_OVERHEAD + 8'h02
                        && cksum_r == cks(subcmd_r[7:0], subcmd_r[15:8],
                                          xfer_r[0], xfer_r[1])) begin
                        dm_r[subcmd_r[3:0]] <= xfer_r[0];
                        if (subcmd_r[3:0] != 4'hf)
                            dm_r[subcmd_r[3:0] + 4'h1] <= xfer_r[1];
                    end
                end
                default: begin
                    if (ptr_r[7:3] == `A_XFER_HI5)
                        xfer_r[ptr_r[2:0]] <= wr_data;
                end
            endcase
        end
    end
end

// ====================================================================
// Safety, permanent-fail and switch control
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        safety_a_r <= `RST_BYTE;
        safety_b_r <= `RST_BYTE;
        safety_c_r <= `RST_BYTE;
        pf_a_r     <= `RST_BYTE;
        pf_b_r     <= `RST_BYTE;
        pf_c_r     <= `RST_BYTE;
        fet_off    <= 1'b0;
    end else begin
        safety_a_r <= fault_a & dm_r[`DM_PROT_EN_A];
        safety_b_r <= fault_b & dm_r[`DM_PROT_EN_A + 4'h1];
        safety_c_r <= fault_c & dm_r[`DM_PROT_EN_A + 4'h2];
        fet_off <= |(safety_a_r & dm_r[`DM_FET_CTL_A]) |
                   |(safety_b_r & dm_r[`DM_FET_CTL_A + 4'h1]) |
                   |(safety_c_r & dm_r[`DM_FET_CTL_A + 4'h2]);
        // Permanent-fail flags hold until device reset
        pf_a_r <= pf_a_r | (permanent_fail_a & dm_r[`DM_PF_EN_A]);
        pf_b_r <= pf_b_r | (permanent_fail_b & dm_r[`DM_PF_EN_A + 4'h1]);
        pf_c_r <= pf_c_r | (permanent_fail_c & dm_r[`DM_PF_EN_A + 4'h2]);
    end
end

// ====================================================================
// Latched alarm status, set wins over clear
wire any_safety = |{safety_a_r, safety_b_r, safety_c_r};
wire any_pf     = |{pf_a_r, pf_b_r, pf_c_r};
wire [15:0] alarm_raw = alarm_in | {1'b0, any_safety, any_pf, 13'h0000};
wire [15:0] alarm_msk = alarm_raw &
                        {dm_r[`DM_ALM_MASK_HI], dm_r[`DM_ALM_MASK_LO]};
wire [15:0] alarm_set = alarm_msk & ~alarm_prev_r;
wire [15:0] alarm_clr =
    (data_wr && ptr_r == `A_ALARM_LO) ? {8'h00, wr_data} :
    (data_wr && ptr_r == `A_ALARM_HI) ? {wr_data, 8'h00} : 16'h0000;

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        alarm_r      <= `RST_WORD;
        alarm_prev_r <= `RST_WORD;
    end else begin
        alarm_prev_r <= alarm_msk;
        alarm_r      <= (alarm_r & ~alarm_clr) | alarm_set;
    end
end

assign alert_out = |alarm_r;

// ====================================================================
// Read data selection, low byte at the even address
always @* begin
    case (ptr_r)
        `A_SAFETY_A:  rd_byte = safety_a_r;
        `A_SAFETY_B:  rd_byte = safety_b_r;
        `A_SAFETY_C:  rd_byte = safety_c_r;
        `A_PF_A:      rd_byte = pf_a_r;
        `A_PF_B:      rd_byte = pf_b_r;
        `A_PF_C:      rd_byte = pf_c_r;
        `A_SUBCMD_LO: rd_byte = subcmd_r[7:0];
        `A_SUBCMD_HI: rd_byte = subcmd_r[15:8];
        `A_CKSUM:     rd_byte = cksum_r;
        `A_LEN:       rd_byte = len_r;
        `A_ALARM_LO:  rd_byte = alarm_r[7:0];
        `A_ALARM_HI:  rd_byte = alarm_r[15:8];
        `A_TEMP1_LO:  rd_byte = thermistor_input_1[7:0];
        `A_TEMP1_HI:  rd_byte = thermistor_input_1[15:8];
        `A_TEMP2_LO:  rd_byte = thermistor_input_2[7:0];
        `A_TEMP2_HI:  rd_byte = thermistor_input_2[15:8];
        `A_TEMP3_LO:  rd_byte = thermistor_input_3[7:0];
        `A_TEMP3_HI:  rd_byte = thermistor_input_3[15:8];
        default: begin
            if (ptr_r[7:3] == `A_XFER_HI5)
                rd_byte = xfer_r[ptr_r[2:0]];
            else
                rd_byte = 8'h00;
        end
    endcase
end

endmodule // battery_monitor_cmd_port
`default_nettype wire

/* batmon_chk.sv */
// Pin-level checker for the battery monitor command port.
// Assumes it is bound to battery_monitor_cmd_port, one clock domain.
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// Port checker
module batmon_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // Bus pins
    input wire logic        scl_in,
    input wire logic        sda_oe,
    // Sources
    input wire logic [7:0]  fault_a,
    input wire logic [7:0]  fault_b,
    input wire logic [7:0]  fault_c,
    input wire logic [15:0] alarm_in,
    // Outputs
    input wire logic        alert_out,
    input wire logic        fet_off,
    input wire logic        shutdown_pulse,
    input wire logic        reset_pulse
);
    logic [3:0] scl_hi_cnt;

    // Cycles SCL has stayed high, saturating; 8 or more means idle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_hi_cnt <= 4'h0;
        end else if (!scl_in) begin
            scl_hi_cnt <= 4'h0;
        end else if (scl_hi_cnt != 4'hf) begin
            scl_hi_cnt <= scl_hi_cnt + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("SDA drive changed while SCL high");
    a_idle_release: assert property (scl_hi_cnt >= 4'h8 |-> !sda_oe)
        else $error("SDA held on idle bus");
    a_alert_latch: assert property ($rose(alarm_in[0]) |-> ##[1:3] alert_out)
        else $error("alarm rise not latched");
    a_alert_kept: assert property (scl_hi_cnt >= 4'h8 && alert_out |=> alert_out)
        else $error("alert dropped without a write");
    a_shut_pulse: assert property (shutdown_pulse |=> !shutdown_pulse)
        else $error("shutdown pulse too long");
    a_reset_pulse: assert property (reset_pulse |=> !reset_pulse)
        else $error("reset pulse too long");
    a_cmd_on_bus: assert property ((shutdown_pulse || reset_pulse) |-> scl_hi_cnt < 4'h8)
        else $error("command pulse without bus write");
    a_fet_release: assert property ((fault_a == 8'h00 && fault_b == 8'h00 && fault_c == 8'h00) [*3] |-> !fet_off)
        else $error("switch off without fault");
    a_quiet_start: assert property ($rose(rst_b) |-> !sda_oe && !alert_out && !fet_off)
        else $error("outputs active at reset release");

    // Main scenarios
    c_shutdown: cover property (shutdown_pulse);
    c_reset: cover property (reset_pulse);
    c_alert_clear: cover property ($fell(alert_out));
    c_fet_off: cover property (fet_off);
endmodule // batmon_chk

bind battery_monitor_cmd_port batmon_chk i_chk (
    .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_in),
    .sda_oe(sda_oe), .fault_a(fault_a),
    .fault_b(fault_b), .fault_c(fault_c), .alarm_in(alarm_in),
    .alert_out(alert_out), .fet_off(fet_off),
    .shutdown_pulse(shutdown_pulse), .reset_pulse(reset_pulse));
`default_nettype wire

/* i2c_host_model.sv */
// Behavioural bus controller facing the command port.
// Assumes an SDA pull-up resolved by the bench; bit period 400 ns.
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// Host controller model
module i2c_host_model (
    // Bus lines
    output var logic scl,
    output var logic sda_low,
    input wire logic sda
);
    // Bus released at start
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Low 300 ns leaves the target time to release SDA
    task automatic bit_out(input logic b);
        #250 sda_low = !b;
        #50 scl = 1'b1;
        #100 scl = 1'b0;
    endtask

    // Sample mid high phase
    task automatic bit_in(output logic b);
        sda_low = 1'b0;
        #300 scl = 1'b1;
        #50 b = sda;
        #50 scl = 1'b0;
    endtask

    // Start or repeated start: SDA falls while SCL high
    task automatic start();
        #250 sda_low = 1'b0;
        #50 scl = 1'b1;
        #200 sda_low = 1'b1;
        #200 scl = 1'b0;
    endtask

    // Stop: SDA rises while SCL high
    task automatic stop();
        #250 sda_low = 1'b1;
        #50 scl = 1'b1;
        #200 sda_low = 1'b0;
        #400;
    endtask

    // Byte out, MSB first, then the target's acknowledge
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        bit_in(x);
        ack = !x;
    endtask

    // Byte in, then acknowledge or not
    task automatic rbyte(output logic [7:0] b, input logic nack);
        for (int i = 7; i >= 0; i--) bit_in(b[i]);
        bit_out(nack);
    endtask
endmodule // i2c_host_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the battery monitor command port.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "batmon_defs.vh"

// ====================================================================
// Bench top
module tb;
    logic        core_clk, rst_b, scl, host_low, sda_oe, sda_out;
    logic        alert_out, fet_off, shutdown_pulse, reset_pulse;
    logic [7:0]  fault_a, fault_b, fault_c, d0, d1;
    logic [7:0]  permanent_fail_a, permanent_fail_b, permanent_fail_c;
    logic [15:0] alarm_in, v, thermistor_input_1;
    logic [15:0] thermistor_input_2, thermistor_input_3;
    logic [63:0] passed_charge_status;
    logic [7:0]  wbuf [0:7];
    logic [7:0]  rbuf [0:7];
    int          errors, num_checks, n_shut, n_rst, seed;
    wire         sda = !(host_low || sda_oe);

    battery_monitor_cmd_port i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .fault_a(fault_a), .fault_b(fault_b), .fault_c(fault_c),
        .permanent_fail_a(permanent_fail_a),
        .permanent_fail_b(permanent_fail_b),
        .permanent_fail_c(permanent_fail_c), .alarm_in(alarm_in),
        .thermistor_input_1(thermistor_input_1),
        .thermistor_input_2(thermistor_input_2),
        .thermistor_input_3(thermistor_input_3),
        .passed_charge_status(passed_charge_status),
        .alert_out(alert_out), .fet_off(fet_off),
        .shutdown_pulse(shutdown_pulse), .reset_pulse(reset_pulse));
    i2c_host_model i_host (.scl(scl), .sda_low(host_low), .sda(sda));

    // Clock and command pulse counters
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (shutdown_pulse === 1'b1) n_shut++;
        if (reset_pulse === 1'b1) n_rst++;
    end

    task automatic chk(input logic [63:0] got_v, input logic [63:0] exp);
        num_checks++;
        if (got_v !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got_v, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Register write and read bursts
    task automatic wr(input logic [7:0] a, input int n);
        logic ack;
        i_host.start();
        i_host.wbyte({`DEV_ADDR, 1'b0}, ack);
        chk(ack, 1'b1);
        i_host.wbyte(a, ack);
        for (int i = 0; i < n; i++) i_host.wbyte(wbuf[i], ack);
        i_host.stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic ack;
        i_host.start();
        i_host.wbyte({`DEV_ADDR, 1'b0}, ack);
        i_host.wbyte(a, ack);
        i_host.start();
        i_host.wbyte({`DEV_ADDR, 1'b1}, ack);
        for (int i = 0; i < n; i++) i_host.rbyte(rbuf[i], i == n - 1);
        i_host.stop();
    endtask

    // Read bytes assembled least significant first
    function automatic logic [63:0] got(input int n);
        logic [63:0] r;
        r = 64'h0;
        for (int i = n - 1; i >= 0; i--) r = {r[55:0], rbuf[i]};
        return r;
    endfunction
    function automatic logic [7:0] cks(input logic [15:0] c,
        input logic [7:0] a, input logic [7:0] b, input int n);
        return ~(c[7:0] + c[15:8] + a + ((n == 2) ? b : 8'h00));
    endfunction

    // Data subcommands: code, data, checksum plus length
    task automatic subw(input logic [15:0] c, input int n,
        input logic [7:0] a, input logic [7:0] b, input logic [7:0] bad);
        wbuf[0] = c[7:0];
        wbuf[1] = c[15:8];
        wr(`A_SUBCMD_LO, 2);
        wbuf[0] = a;
        wbuf[1] = b;
        wr({`A_XFER_HI5, 3'h0}, n);
        wbuf[0] = cks(c, a, b, n) ^ bad;
        wbuf[1] = `LEN_OVERHEAD + 8'(n);
        wr(`A_CKSUM, 2);
    endtask
    task automatic subr(input logic [15:0] c, input int n);
        wbuf[0] = c[7:0];
        wbuf[1] = c[15:8];
        wr(`A_SUBCMD_LO, 2);
        rd({`A_XFER_HI5, 3'h0}, n);
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (90000) @(posedge core_clk);
        errors++;
        $display("Error at %0t: run timed out", $time);
        results();
    end

    // Main sequence
    initial begin
        {errors, num_checks, n_shut, n_rst} = '0;
        {rst_b, fault_a, fault_b, fault_c, alarm_in} = '0;
        {permanent_fail_a, permanent_fail_b, permanent_fail_c} = '0;
        {thermistor_input_1, thermistor_input_2, thermistor_input_3} = '0;
        passed_charge_status = 64'h0;
        seed = $urandom(39);
        tick(8);
        chk({sda_oe, sda_out}, 2'b00);
        chk(alert_out, 1'b0);
        rst_b = 1'b1;
        tick(4);
        rd(8'h01, 1);
        chk(rbuf[0], 8'h00);
        $display("done: reset and unmapped");
        v = 16'($urandom()) & 16'h9fff | 16'h0001;
        alarm_in = v;
        tick(3);
        chk(alert_out, 1'b1);
        rd(`A_ALARM_LO, 2);
        chk(got(2), v);
        wbuf[0] = 8'hff;
        wbuf[1] = 8'h00;
        wr(`A_ALARM_LO, 2);
        rd(`A_ALARM_LO, 2);
        chk(got(2), v & 16'hff00);
        wbuf[1] = 8'hff;
        wr(`A_ALARM_LO, 2);
        tick(2);
        chk(alert_out, 1'b0);
        alarm_in = 16'h0;
        $display("done: alarm");
        {thermistor_input_1, thermistor_input_2} = $urandom();
        thermistor_input_3 = 16'($urandom());
        rd(`A_TEMP1_LO, 6);
        chk(got(6), {thermistor_input_3, thermistor_input_2,
            thermistor_input_1});
        $display("done: temperatures");
        tick(1);
        {fault_a, fault_b, fault_c} = 24'($urandom()) | 24'h1;
        {permanent_fail_a, permanent_fail_b, permanent_fail_c} =
            24'($urandom());
        tick(3);
        chk(fet_off, 1'b1);
        for (int k = 0; k < 3; k++) begin
            rd(`A_SAFETY_A + 8'(2 * k), 1);
            chk(rbuf[0], k == 0 ? fault_a : k == 1 ? fault_b : fault_c);
            rd(`A_PF_A + 8'(2 * k), 1);
            chk(rbuf[0], k == 0 ? permanent_fail_a : k == 1 ?
                permanent_fail_b : permanent_fail_c);
        end
        chk(alert_out, 1'b1);
        tick(1);
        {fault_a, fault_b, fault_c} = 24'h0;
        tick(3);
        chk(fet_off, 1'b0);
        subw(16'h9000, 1, 8'h00, 8'h00, 8'h00);
        tick(1);
        fault_a = 8'hff;
        tick(3);
        rd(`A_SAFETY_A, 1);
        chk({fet_off, rbuf[0]}, 9'h000);
        fault_a = 8'h00;
        $display("done: fault flags");
        d0 = 8'($urandom()) | 8'h01;
        d1 = 8'($urandom());
        subw(16'h9009, 2, d0, d1, 8'h00);
        subr(16'h9009, 2);
        chk(got(2), {d1, d0});
        subw(16'h9009, 1, d0 ^ 8'h02, 8'h00, 8'h01);
        subr(16'h9009, 2);
        chk(got(2), {d1, d0});
        $display("done: data subcommands");
        tick(1);
        passed_charge_status = {$urandom(), $urandom()};
        subr(`SC_PASSED_CHG, 8);
        chk(got(8), passed_charge_status);
        for (int k = 0; k < 2; k++) begin
            wbuf[0] = 8'(k == 0 ? `SC_SHUTDOWN : `SC_RESET);
            wbuf[1] = 8'h00;
            wr(`A_SUBCMD_LO, 2);
        end
        chk({n_shut, n_rst}, {32'd1, 32'd1});
        $display("done: commands");
        results();
    end
endmodule // tb
`default_nettype wire
